// File: hw/cmi_ctrl.sv
// CAN mode control, abort and interrupt-code core with Wishbone slave
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ns
// Contract
// - Request 1xx config; 011,010,001,000 other modes
// - Status reports the mode actually in effect
// - Config switch waits for idle bus
// - Other modes take effect immediately
// - Abort bit set-only; aborts all pending transmissions
// - Legacy window code selects TX0/1/2, RX1, else RX0
// - Window output maps chosen buffer into access area
// - FIFO mode: low control bits show read pointer
// - Pending interrupt gives prioritized source code
// - Legacy codes: none,error,TX2,TX1,TX0,RX1,RX0
// - Legacy code 111 means wake-up
// - Enhanced five-bit codes per buffer source
// - FIFO receive programmable buffer reports 10000
// - Legacy interrupt codes line up with window codes
// - Legacy code in bits 3-1, enhanced in 4-0
// - Layout select: legacy, enhanced, FIFO, reserved
// - Layout select changes only in configuration mode
module cmi_ctrl
  import cmi_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  // Wishbone classic slave
  input  wire logic         wb_cyc_in,
  input  wire logic         wb_stb_in,
  input  wire logic         wb_we_in,
  input  wire logic [3:0]   wb_adr_in,
  input  wire logic [3:0]   wb_sel_in,
  input  wire logic [31:0]  wb_dat_in,
  output logic      [31:0]  wb_dat_out,
  output logic              wb_ack_out,
  // Protocol engine and buffers
  input  wire logic         bus_idle_in,
  input  wire logic         tx_pending_in,
  input  wire logic [2:0]   fifo_ptr_in,
  input  wire cmi_irq_src_t irq_src_in,
  // Control outputs
  output logic [2:0]        mode_status_out,
  output logic [1:0]        op_mode_out,
  output logic              abort_all_tx_out,
  output logic [4:0]        buf_window_out
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_WAIT = 3'b010,
    ST_CFG  = 3'b100
  } cmi_state_t;

  cmi_state_t  state_q;
  logic [2:0]  req_q;
  logic        abort_q;
  logic [2:0]  win_q;
  logic [4:0]  ewin_q;
  cmi_opm_t    opm_q;
  logic [2:0]  mode_q;
  logic [4:0]  code_q;
  logic [4:0]  code_d;
  logic [7:0]  ctrl_rd;
  logic [7:0]  stat_rd;
  logic [7:0]  ectl_rd;
  logic        wb_req;
  logic        wr_ctrl;
  logic        wr_ectl;
  logic        req_cfg;
  logic [2:0]  req_mode;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Writes need lane 0; registers are eight bits in the low byte
  assign wb_req  = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_ctrl = wb_req && wb_we_in && wb_sel_in[0] &&
                   (wb_adr_in == CMI_OFS_CONTROL);
  assign wr_ectl = wb_req && wb_we_in && wb_sel_in[0] &&
                   (wb_adr_in == CMI_OFS_ENH_CTRL);

  // Any set top bit is a configuration request
  assign req_cfg  = req_q[2];
  assign req_mode = req_cfg ? CMI_MODE_CONFIG : req_q;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Request field is plain read/write; the window is written only in legacy layout
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      req_q <= CMI_RST_REQ;
      win_q <= CMI_RST_WIN;
    end else if (wr_ctrl) begin
      req_q <= wb_dat_in[CMI_POS_REQ +: 3];
      if (opm_q == CMI_OPM_LEGACY) begin
        win_q <= wb_dat_in[CMI_POS_WIN +: 3];
      end
    end
  end

  // Abort is set by software only; hardware drops it once nothing
  // is pending, and a write setting it in that cycle wins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      abort_q <= 1'b0;
    end else if (wr_ctrl && wb_dat_in[CMI_POS_ABORT]) begin
      abort_q <= 1'b1;
    end else if (!tx_pending_in) begin
      abort_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Enhanced control: layout select and extended window
  // ----------------------------------------------------------------
  // Layout may only move while in configuration mode; the reserved
  // code is refused so the layout is always a defined one
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      opm_q  <= CMI_OPM_LEGACY;
      ewin_q <= CMI_RST_EWIN;
    end else if (wr_ectl) begin
      if (mode_q == CMI_MODE_CONFIG &&
          wb_dat_in[CMI_POS_OPMODE +: 2] != CMI_OPM_RSVD) begin
        opm_q <= cmi_opm_t'(wb_dat_in[CMI_POS_OPMODE +: 2]);
      end
      ewin_q <= wb_dat_in[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  // Configuration is entered only on an idle bus so no frame is cut;
  // every other mode follows the request on the next edge
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_CFG;
      mode_q  <= CMI_MODE_CONFIG;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (req_cfg) begin
            state_q <= ST_WAIT;
          end else begin
            mode_q <= req_mode;
          end
        end
        ST_WAIT: begin
          if (!req_cfg) begin
            state_q <= ST_RUN;
            mode_q  <= req_mode;
          end else if (bus_idle_in) begin
            state_q <= ST_CFG;
            mode_q  <= CMI_MODE_CONFIG;
          end
        end
        ST_CFG: begin
          if (!req_cfg) begin
            state_q <= ST_RUN;
            mode_q  <= req_mode;
          end
        end
        default: begin
          state_q <= ST_CFG;
          mode_q  <= CMI_MODE_CONFIG;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt source priority encoder
  // ----------------------------------------------------------------
  // Fixed priority: error, TX0, TX1, TX2, RX0, RX1, programmable
  // buffers low first, wake-up last. Legacy codes are the window codes.
  always_comb begin
    code_d = CMI_EC_NONE;
    if (opm_q == CMI_OPM_LEGACY) begin
      if (irq_src_in.err)       code_d = {1'b0, CMI_LC_ERR, 1'b0};
      else if (irq_src_in.tx0)  code_d = {1'b0, CMI_LC_TX0, 1'b0};
      else if (irq_src_in.tx1)  code_d = {1'b0, CMI_LC_TX1, 1'b0};
      else if (irq_src_in.tx2)  code_d = {1'b0, CMI_LC_TX2, 1'b0};
      else if (irq_src_in.rx0)  code_d = {1'b0, CMI_LC_RX0, 1'b0};
      else if (irq_src_in.rx1)  code_d = {1'b0, CMI_LC_RX1, 1'b0};
      else if (irq_src_in.wake) code_d = {1'b0, CMI_LC_WAKE, 1'b0};
    end else begin
      if (irq_src_in.err)       code_d = CMI_EC_ERR;
      else if (irq_src_in.tx0)  code_d = CMI_EC_TX0;
      else if (irq_src_in.tx1)  code_d = CMI_EC_TX1;
      else if (irq_src_in.tx2)  code_d = CMI_EC_TX2;
      else if (irq_src_in.rx0)  code_d = CMI_EC_RX0;
      else if (irq_src_in.rx1)  code_d = (opm_q == CMI_OPM_FIFO) ?
                                         CMI_EC_RX0 : CMI_EC_RX1;
      else if (|irq_src_in.prg) begin
        for (int i = CMI_NUM_PRG - 1; i >= 0; i--) begin
          if (irq_src_in.prg[i]) begin
            if (opm_q == CMI_OPM_FIFO && irq_src_in.prg_is_rx[i]) begin
              code_d = CMI_EC_RX0;
            end else begin
              code_d = CMI_EC_PRG0 + 5'(i);
            end
          end
        end
      end
      else if (irq_src_in.wake) code_d = CMI_EC_WAKE;
    end
  end

  // Code is registered so a read sees one consistent value
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      code_q <= CMI_EC_NONE;
    end else begin
      code_q <= code_d;
    end
  end

  // ----------------------------------------------------------------
  // Read views per layout
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_rd = {req_q, abort_q, 4'h0};
    case (opm_q)
      CMI_OPM_LEGACY: ctrl_rd[3:0] = {win_q, 1'b0};
      CMI_OPM_FIFO:   ctrl_rd[3:0] = {1'b0, fifo_ptr_in};
      default:        ctrl_rd[3:0] = 4'h0;
    endcase
  end

  // Legacy view masks bits 4 and 0: the code register lags a layout
  // change by a cycle and may still hold a five-bit extended code
  assign stat_rd = (opm_q == CMI_OPM_LEGACY) ?
                   {mode_q, 1'b0, code_q[3:1], 1'b0} :
                   {mode_q, code_q};
  assign ectl_rd = {opm_q, 1'b0,
                    (opm_q == CMI_OPM_LEGACY) ? 5'h00 : ewin_q};

  // ----------------------------------------------------------------
  // Wishbone answer: ack one cycle after the request, unmapped reads 0
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_req;
      if (wb_req && !wb_we_in) begin
        case (wb_adr_in)
          CMI_OFS_CONTROL:  wb_dat_out <= {24'h000000, ctrl_rd};
          CMI_OFS_STATUS:   wb_dat_out <= {24'h000000, stat_rd};
          CMI_OFS_ENH_CTRL: wb_dat_out <= {24'h000000, ectl_rd};
          default:          wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs toward the core
  // ----------------------------------------------------------------
  // Legacy window decoded to the buffer it maps; enhanced passes on
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      buf_window_out <= CMI_WIN_RX_BUFFER_0;
    end else if (opm_q == CMI_OPM_LEGACY) begin
      case (win_q)
        CMI_LC_TX0: buf_window_out <= CMI_WIN_TX_BUFFER_0;
        CMI_LC_TX1: buf_window_out <= CMI_WIN_TX_BUFFER_1;
        CMI_LC_TX2: buf_window_out <= CMI_WIN_TX_BUFFER_2;
        CMI_LC_RX1: buf_window_out <= CMI_WIN_RX_BUFFER_1;
        default:    buf_window_out <= CMI_WIN_RX_BUFFER_0;
      endcase
    end else begin
      buf_window_out <= ewin_q;
    end
  end

  // Mirrors for the engine; one cycle behind their registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_status_out  <= CMI_MODE_CONFIG;
      op_mode_out      <= CMI_OPM_LEGACY;
      abort_all_tx_out <= 1'b0;
    end else begin
      mode_status_out  <= mode_q;
      op_mode_out      <= opm_q;
      abort_all_tx_out <= abort_q;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_cfg_needs_idle: assert property (
    (mode_q != CMI_MODE_CONFIG) ##1 (mode_q == CMI_MODE_CONFIG)
      |-> $past(bus_idle_in))
    else $error("config entered on busy bus");
  chk_mode_follows: assert property (
    (state_q == ST_RUN && !req_cfg) |=> (mode_q == $past(req_q)))
    else $error("mode did not follow request");
  chk_cfg_reached: assert property (
    (state_q == ST_WAIT && req_cfg && bus_idle_in)
      |=> (mode_q == CMI_MODE_CONFIG) ##1
          (mode_status_out == CMI_MODE_CONFIG))
    else $error("config not reported");
  chk_abort_holds: assert property (
    (abort_q && tx_pending_in) |=> abort_q)
    else $error("abort dropped while pending");
  chk_abort_set: assert property (
    (wr_ctrl && wb_dat_in[CMI_POS_ABORT]) |=> abort_q ##1 abort_all_tx_out)
    else $error("abort write lost");
  chk_opm_locked: assert property (
    (mode_q != CMI_MODE_CONFIG) |=> $stable(opm_q))
    else $error("layout changed outside config");
  chk_legacy_bits: assert property (
    (wb_req && !wb_we_in && wb_adr_in == CMI_OFS_STATUS &&
     opm_q == CMI_OPM_LEGACY)
      |=> ((wb_dat_out[4:0] & 5'h11) == 5'h00))
    else $error("legacy status bits 4 or 0 set");
  chk_fifo_rx_code: assert property (
    (opm_q == CMI_OPM_FIFO && !irq_src_in.err && !irq_src_in.tx0 &&
     !irq_src_in.tx1 && !irq_src_in.tx2 && !irq_src_in.rx0 &&
     !irq_src_in.rx1 && irq_src_in.prg[0] && irq_src_in.prg_is_rx[0])
      |=> (code_q == CMI_EC_RX0))
    else $error("FIFO receive buffer code wrong");
  chk_no_irq_zero: assert property (
    (irq_src_in == '0) |=> (code_q == CMI_EC_NONE))
    else $error("code without interrupt");
  chk_win_tx0_map: assert property (
    (opm_q == CMI_OPM_LEGACY && win_q == CMI_LC_TX0)
      |=> (buf_window_out == CMI_WIN_TX_BUFFER_0))
    else $error("legacy window TX0 misdecoded");
  chk_ack_single: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");

  cov_cfg_wait: cover property (
    state_q == ST_WAIT ##1 state_q == ST_CFG);
  cov_abort_done: cover property (abort_q ##1 !abort_q);
  cov_fifo_code: cover property (
    opm_q == CMI_OPM_FIFO && code_q == CMI_EC_RX0);
  cov_loopback: cover property (mode_q == CMI_MODE_LOOPBACK);

endmodule

// File: include/cmi_pkg.sv
// Package for the CAN mode and interrupt-code control core
package cmi_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on a 32-bit Wishbone bus)
  // ----------------------------------------------------------------
  localparam logic [3:0] CMI_OFS_CONTROL  = 4'h0;
  localparam logic [3:0] CMI_OFS_STATUS   = 4'h4;
  localparam logic [3:0] CMI_OFS_ENH_CTRL = 4'h8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CMI_POS_REQ       = 5;
  localparam int         CMI_POS_ABORT     = 4;
  localparam int         CMI_POS_WIN       = 1;
  localparam int         CMI_POS_OPMODE    = 6;
  localparam logic [2:0] CMI_RST_REQ       = 3'h4;
  localparam logic [2:0] CMI_RST_WIN       = 3'h0;
  localparam logic [4:0] CMI_RST_EWIN      = 5'h00;

  // ----------------------------------------------------------------
  // Mode codes (request and status share the encoding)
  // ----------------------------------------------------------------
  localparam logic [2:0] CMI_MODE_NORMAL   = 3'h0;
  localparam logic [2:0] CMI_MODE_DISABLE  = 3'h1;
  localparam logic [2:0] CMI_MODE_LOOPBACK = 3'h2;
  localparam logic [2:0] CMI_MODE_LISTEN   = 3'h3;
  localparam logic [2:0] CMI_MODE_CONFIG   = 3'h4;

  // Operating layouts
  typedef enum logic [1:0] {
    CMI_OPM_LEGACY   = 2'h0,
    CMI_OPM_ENHANCED = 2'h1,
    CMI_OPM_FIFO     = 2'h2,
    CMI_OPM_RSVD     = 2'h3
  } cmi_opm_t;

  // ----------------------------------------------------------------
  // Interrupt codes: legacy three-bit and extended five-bit
  // ----------------------------------------------------------------
  localparam logic [2:0] CMI_LC_NONE  = 3'h0;
  localparam logic [2:0] CMI_LC_ERR   = 3'h1;
  localparam logic [2:0] CMI_LC_TX2   = 3'h2;
  localparam logic [2:0] CMI_LC_TX1   = 3'h3;
  localparam logic [2:0] CMI_LC_TX0   = 3'h4;
  localparam logic [2:0] CMI_LC_RX1   = 3'h5;
  localparam logic [2:0] CMI_LC_RX0   = 3'h6;
  localparam logic [2:0] CMI_LC_WAKE  = 3'h7;
  localparam logic [4:0] CMI_EC_NONE  = 5'h00;
  localparam logic [4:0] CMI_EC_ERR   = 5'h02;
  localparam logic [4:0] CMI_EC_TX2   = 5'h04;
  localparam logic [4:0] CMI_EC_TX1   = 5'h06;
  localparam logic [4:0] CMI_EC_TX0   = 5'h08;
  localparam logic [4:0] CMI_EC_WAKE  = 5'h0e;
  localparam logic [4:0] CMI_EC_RX0   = 5'h10;
  localparam logic [4:0] CMI_EC_RX1   = 5'h11;
  localparam logic [4:0] CMI_EC_PRG0  = 5'h12;

  // Buffer window codes presented on the window output
  localparam logic [4:0] CMI_WIN_TX_BUFFER_0 = 5'h03;
  localparam logic [4:0] CMI_WIN_TX_BUFFER_1 = 5'h04;
  localparam logic [4:0] CMI_WIN_TX_BUFFER_2 = 5'h05;
  localparam logic [4:0] CMI_WIN_RX_BUFFER_0 = 5'h10;
  localparam logic [4:0] CMI_WIN_RX_BUFFER_1 = 5'h11;

  localparam int CMI_NUM_PRG = 6;

  // Interrupt sources from the protocol engine and buffers
  typedef struct packed {
    logic                   err;
    logic                   tx2;
    logic                   tx1;
    logic                   tx0;
    logic                   rx1;
    logic                   rx0;
    logic                   wake;
    logic [CMI_NUM_PRG-1:0] prg;
    logic [CMI_NUM_PRG-1:0] prg_is_rx;
  } cmi_irq_src_t;

endpackage

// File: test/cmi_engine_model.sv
// Behavioural protocol-engine and buffer model facing the control core
`timescale 1ns/1ns
module cmi_engine_model
  import cmi_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  // Commands from the bench
  input  wire logic         busy_cmd_in,
  input  wire logic         tx_load_in,
  input  wire logic [2:0]   ptr_cmd_in,
  input  wire cmi_irq_src_t irq_cmd_in,
  // From the control core
  input  wire logic         abort_all_tx_in,
  // To the control core
  output logic              bus_idle_out,
  output logic              tx_pending_out,
  output logic [2:0]        fifo_ptr_out,
  output cmi_irq_src_t      irq_src_out
);
  logic       pend_q;
  logic [4:0] abt_cnt_q;

  // Bus counts as idle only while no frame is in flight
  assign bus_idle_out   = ~busy_cmd_in;
  assign fifo_ptr_out   = ptr_cmd_in;
  assign irq_src_out    = irq_cmd_in;
  assign tx_pending_out = pend_q;

  // Abort is deliberately slow: the frame in flight ends first, so the
  // core has to hold its abort request for many cycles
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pend_q    <= 1'b0;
      abt_cnt_q <= 5'h00;
    end else if (tx_load_in) begin
      pend_q <= 1'b1;
    end else if (pend_q && abort_all_tx_in) begin
      abt_cnt_q <= abt_cnt_q + 5'h01;
      if (abt_cnt_q == 5'h1f) begin
        pend_q <= 1'b0;
      end
    end else begin
      abt_cnt_q <= 5'h00;
    end
  end
endmodule

// File: test/cmi_ctrl_tb.sv
// Self-checking bench for the CAN mode and interrupt-code core
`timescale 1ns/1ns
module cmi_ctrl_tb
  import cmi_pkg::*;
;
  logic         clk_in     = 1'b0;
  logic         sys_rst_in = 1'b1;
  logic         wb_cyc     = 1'b0;
  logic         wb_stb     = 1'b0;
  logic         wb_we      = 1'b0;
  logic [3:0]   wb_adr     = 4'h0;
  logic [31:0]  wb_dat     = 32'h00000000;
  logic         busy       = 1'b0;
  logic         tx_load    = 1'b0;
  logic [2:0]   ptr        = 3'h0;
  logic [18:0]  irq        = 19'h00000;
  logic [31:0]  wb_dat_out;
  logic         wb_ack_out;
  logic         bus_idle;
  logic         tx_pending;
  logic [2:0]   fifo_ptr;
  cmi_irq_src_t irq_src;
  logic [2:0]   mode_status_out;
  logic [1:0]   op_mode_out;
  logic         abort_all_tx_out;
  logic [4:0]   buf_window_out;
  int           err_total  = 0;
  int           n_compared = 0;
  // Legacy window expected for interrupt codes 0 to 7
  logic [7:0]   lwin [8] = '{8'h10, 8'h10, 8'h05, 8'h04,
                             8'h03, 8'h11, 8'h10, 8'h10};
  int           ebit [7] = '{18, 17, 16, 15, 12, 13, 14};
  logic [7:0]   ecode [7] = '{8'h02, 8'h04, 8'h06, 8'h08,
                              8'h0e, 8'h10, 8'h11};

  // 10 MHz clock
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  cmi_ctrl dut_u (
    .clk_in           (clk_in),
    .sys_rst_in       (sys_rst_in),
    .wb_cyc_in        (wb_cyc),
    .wb_stb_in        (wb_stb),
    .wb_we_in         (wb_we),
    .wb_adr_in        (wb_adr),
    .wb_sel_in        (4'hf),
    .wb_dat_in        (wb_dat),
    .wb_dat_out       (wb_dat_out),
    .wb_ack_out       (wb_ack_out),
    .bus_idle_in      (bus_idle),
    .tx_pending_in    (tx_pending),
    .fifo_ptr_in      (fifo_ptr),
    .irq_src_in       (irq_src),
    .mode_status_out  (mode_status_out),
    .op_mode_out      (op_mode_out),
    .abort_all_tx_out (abort_all_tx_out),
    .buf_window_out   (buf_window_out)
  );

  cmi_engine_model eng_u (
    .clk_in          (clk_in),
    .sys_rst_in      (sys_rst_in),
    .busy_cmd_in     (busy),
    .tx_load_in      (tx_load),
    .ptr_cmd_in      (ptr),
    .irq_cmd_in      (cmi_irq_src_t'(irq)),
    .abort_all_tx_in (abort_all_tx_out),
    .bus_idle_out    (bus_idle),
    .tx_pending_out  (tx_pending),
    .fifo_ptr_out    (fifo_ptr),
    .irq_src_out     (irq_src)
  );

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic wb_io(input logic [3:0] a, input logic w,
                       input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= {24'h000000, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      $display("FAIL wb_ack expected 1 seen 0");
    end
    q = wb_dat_out[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb_io(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(string nm, logic [3:0] a, logic [7:0] e);
    logic [7:0] q;
    wb_io(a, 1'b0, 8'h00, q);
    chk(nm, e, q);
  endtask

  // Lets registered pins catch up before they are looked at
  task automatic settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  // Watchdog: the sequence needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int         n;
    logic [7:0] q;
    logic [7:0] c;
    logic [18:0] s;
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd_chk("ctrl_rst", CMI_OFS_CONTROL, 8'h80);
    rd_chk("stat_rst", CMI_OFS_STATUS, 8'h80);
    rd_chk("enh_rst", CMI_OFS_ENH_CTRL, 8'h00);
    chk("mode_pin_rst", 8'h04, {5'h00, mode_status_out});
    chk("win_pin_rst", 8'h10, {3'h0, buf_window_out});
    chk("abort_rst", 8'h00, {7'h00, abort_all_tx_out});
    // Every request code while a frame is in flight
    @(posedge clk_in);
    busy <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      wr(CMI_OFS_CONTROL, 8'h00);
      wr(CMI_OFS_CONTROL, 8'(r << 5));
      c = (r > 3) ? 8'h00 : 8'(r << 5);
      rd_chk("mode_busy", CMI_OFS_STATUS, c);
      settle();
      chk("mode_pin", c, {mode_status_out, 5'h00});
      if (r > 3) begin
        @(posedge clk_in);
        busy <= 1'b0;
        n = 0;
        do begin
          wb_io(CMI_OFS_STATUS, 1'b0, 8'h00, q);
          n++;
        end while (q[7:5] !== 3'h4 && n < 20);
        chk("mode_cfg", 8'h80, q);
        @(posedge clk_in);
        busy <= 1'b1;
      end
    end
    @(posedge clk_in);
    busy <= 1'b0;
    // Unmapped and read-only places
    wr(4'hc, 8'hff);
    rd_chk("unmapped", 4'hc, 8'h00);
    wr(CMI_OFS_STATUS, 8'h7f);
    rd_chk("stat_ro", CMI_OFS_STATUS, 8'h80);
    // Legacy codes copied straight into the window field
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      irq <= (i == 0) ? 19'h00000 : 19'(1 << (19 - i));
      settle();
      c = 8'(8'h80 | (i << 1));
      rd_chk("icode", CMI_OFS_STATUS, c);
      wr(CMI_OFS_CONTROL, c);
      settle();
      chk("lwin", lwin[i], {3'h0, buf_window_out});
      rd_chk("win_rb", CMI_OFS_CONTROL, c);
    end
    @(posedge clk_in);
    irq <= 19'h7ffff;
    settle();
    rd_chk("prio", CMI_OFS_STATUS, 8'h82);
    wr(CMI_OFS_CONTROL, 8'h80);
    // Abort is set-only and stays while transmissions remain
    @(posedge clk_in);
    irq <= 19'h00000;
    tx_load <= 1'b1;
    @(posedge clk_in);
    tx_load <= 1'b0;
    wr(CMI_OFS_CONTROL, 8'h90);
    rd_chk("abort_set", CMI_OFS_CONTROL, 8'h90);
    chk("abort_pin", 8'h01, {7'h00, abort_all_tx_out});
    wr(CMI_OFS_CONTROL, 8'h80);
    rd_chk("abort_keep", CMI_OFS_CONTROL, 8'h90);
    n = 0;
    while (abort_all_tx_out !== 1'b0 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    rd_chk("abort_done", CMI_OFS_CONTROL, 8'h80);
    // Extended codes in enhanced and FIFO layouts
    for (int l = 1; l < 3; l++) begin
      wr(CMI_OFS_ENH_CTRL, 8'(l << 6));
      settle();
      chk("layout", 8'(l), {6'h00, op_mode_out});
      for (int i = 0; i < 13; i++) begin
        s = (i < 7) ? 19'(1 << ebit[i]) : 19'(1 << (i - 1));
        c = (i < 7) ? ecode[i] : 8'(8'h12 + i - 7);
        if (l == 2 && i > 6 && i[0]) s = s | 19'(1 << (i - 7));
        if (l == 2 && (i == 6 || (i > 6 && i[0]))) c = 8'h10;
        @(posedge clk_in);
        irq <= s;
        settle();
        rd_chk("ecode", CMI_OFS_STATUS, 8'h80 | c);
        wr(CMI_OFS_ENH_CTRL, 8'(l << 6) | c);
        settle();
        chk("ewin", c, {3'h0, buf_window_out});
      end
    end
    for (int p = 0; p < 8; p++) begin
      @(posedge clk_in);
      ptr <= 3'(p);
      rd_chk("fifo_ptr", CMI_OFS_CONTROL, 8'(8'h80 + p));
    end
    // Layout field locked outside configuration, reserved value dropped
    @(posedge clk_in);
    irq <= 19'h00000;
    wr(CMI_OFS_ENH_CTRL, 8'h40);
    rd_chk("enh_ctrl_low", CMI_OFS_CONTROL, 8'h80);
    wr(CMI_OFS_CONTROL, 8'h00);
    wr(CMI_OFS_ENH_CTRL, 8'h80);
    rd_chk("lay_locked", CMI_OFS_ENH_CTRL, 8'h40);
    wr(CMI_OFS_CONTROL, 8'h80);
    settle();
    wr(CMI_OFS_ENH_CTRL, 8'hc0);
    rd_chk("lay_rsvd", CMI_OFS_ENH_CTRL, 8'h40);
    // Software parks the controller in disable before device sleep
    wr(CMI_OFS_CONTROL, 8'h20);
    settle();
    chk("disable_pin", 8'h01, {5'h00, mode_status_out});
    rd_chk("disable_stat", CMI_OFS_STATUS, 8'h20);
    close_out();
  end
endmodule
